// ### verilog/rxdp_pkg.sv
package rxdp_pkg;
    localparam int DATA_AW = 9;
    localparam int STAT_AW = 4;
    localparam int PAD_LOG2 = 2;

    localparam logic [7:0] ADDR_RX_DATA = 8'h00;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h02;
    localparam logic [7:0] ADDR_LEVEL_DATA = 8'h04;
    localparam logic [7:0] ADDR_LEVEL_STAT = 8'h06;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0A;

    localparam int CTL_SKIP_BIT = 0;
    localparam int CTL_FLUSH_BIT = 1;
    localparam int CTL_PAD_BIT = 2;
    localparam int CTL_ENABLE_BIT = 3;
    localparam int CTL_OFFSET_LSB = 8;
    localparam int ERR_FLAG_BIT = 0;
    localparam int ERR_HALTED_BIT = 1;
    localparam int ERR_BUSY_BIT = 2;

    localparam int ST_FILTER_BIT = 30;
    localparam int ST_LEN_LSB = 16;
    localparam int ST_ERROR_SUMMARY_BIT = 15;
    localparam int ST_BCAST_BIT = 13;
    localparam int ST_RUNT_BIT = 11;
    localparam int ST_TOOLONG_BIT = 7;
    localparam int ST_LATECOL_BIT = 6;
    localparam int ST_CRC_BIT = 1;
    localparam logic [12:0] ST_FLAG_MASK = 13'h1CFE;

    localparam logic [4:0] RST_OFFSET = 5'h00;
    localparam logic RST_PAD_EN = 1'b0;
    localparam logic RST_RX_ENABLE = 1'b0;

    typedef enum logic [2:0] {W_IDLE, W_FILL, W_DATA, W_TAIL, W_PAD, W_STAT} rxdp_wstate_type;
endpackage

// ### verilog/rxdp_mem.sv
`timescale 1ns/10ps
module rxdp_mem #(
    parameter int WIDTH = 32,
    parameter int AW = 4
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Read port is registered: data shows one edge after the address settles
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// ### verilog/rxdp_top.sv
`timescale 1ns/10ps
// How it works
// - Frame data is written into data FIFO
// - Status word follows data, in separate FIFO
// - Level register reports queued data and status
// - Status FIFO readable independent of data FIFO
// - Reading empty FIFO raises the error flag
// - Packet start shifted by 0-31 byte offset
// - Optional padding to whole burst multiple
// - Offset and padding applied per packet
// - Skip command drops head packet, self-clears
// - Skip moves data FIFO only, receiver running
// - Flush command resets all pointers, self-clears
// - Length in bits 29:16, bit 31 zero
// - Bit 30 flags address filter failure
// - Bit 15 is OR of 11,7,6,1
// - Bit 13 broadcast, bit 14 zero
// - Each word read as two 16-bit halves
// - Bits 11,7,6,1 carry runt/long/collision/CRC
// - Clearing enable halts receiver with pulse
// - Status FIFO overrun raises the error flag
module rxdp_top
    import rxdp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [1:0] wb_sel_i,
    input wire logic [15:0] wb_dat_i,
    output logic [15:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] mac_data_i,
    input wire logic mac_valid_i,
    input wire logic mac_last_i,
    input wire logic [1:0] mac_last_bytes_i,
    output logic mac_ready_o,
    input wire logic mac_stat_valid_i,
    input wire logic [13:0] mac_stat_len_i,
    input wire logic mac_stat_filter_fail_i,
    input wire logic mac_stat_bcast_i,
    input wire logic [12:0] mac_stat_flags_i,
    output logic mac_stat_ready_o,
    output logic rx_error_flag_o,
    output logic receiver_halted_pulse_o
);
    rxdp_wstate_type wstate_ff, nxt_wstate;
    logic [31:0] carry_ff, nxt_carry;
    logic [1:0] shift_ff, nxt_shift;
    logic [2:0] fill_ff, nxt_fill;
    logic [13:0] wcnt_ff, nxt_wcnt;
    logic [DATA_AW:0] dwr_ptr_ff, nxt_dwr, drd_ptr_ff, nxt_drd, dcount;
    logic [STAT_AW:0] swr_ptr_ff, nxt_swr, srd_ptr_ff, nxt_srd, lrd_ptr_ff, nxt_lrd, scount, lcount;
    logic halted_ff, nxt_halted, halted_pulse_ff;
    logic dwe, swe, stat_ovr, dspace, sfull;
    logic [31:0] dwd, swd, drdata, srdata;
    logic [13:0] lhead;
    logic [2:0] last_bytes;

    logic ack_ff, nxt_ack;
    logic [15:0] dat_ff, nxt_dat;
    logic rx_enable_ff, nxt_rx_enable, pad_en_ff, nxt_pad_en;
    logic skip_ff, nxt_skip, flush_ff, nxt_flush, err_ff, nxt_err;
    logic [4:0] offset_ff, nxt_offset;
    logic dhalf_ff, nxt_dhalf, shalf_ff, nxt_shalf, lready_ff;
    logic [13:0] rd_in_pkt_ff, nxt_rd_in_pkt;
    logic acc, err_set, err_clr, lpop;

    // Byte shifter: new word moved up by s bytes, low bytes from the previous word
    function automatic logic [31:0] merge_word(input logic [31:0] w, input logic [31:0] c, input logic [1:0] s);
        unique case (s)
            2'd0: merge_word = w;
            2'd1: merge_word = {w[23:0], c[7:0]};
            2'd2: merge_word = {w[15:0], c[15:0]};
            2'd3: merge_word = {w[7:0], c[23:0]};
        endcase
    endfunction

    function automatic logic [31:0] spill_word(input logic [31:0] w, input logic [1:0] s);
        unique case (s)
            2'd0: spill_word = 32'h0000_0000;
            2'd1: spill_word = {24'h00_0000, w[31:24]};
            2'd2: spill_word = {16'h0000, w[31:16]};
            2'd3: spill_word = {8'h00, w[31:8]};
        endcase
    endfunction

    assign dcount = dwr_ptr_ff - drd_ptr_ff;
    assign scount = swr_ptr_ff - srd_ptr_ff;
    assign lcount = swr_ptr_ff - lrd_ptr_ff;
    assign dspace = ~dcount[DATA_AW];
    // Length queue fills in step with the status queue but drains with data reads
    assign sfull = scount[STAT_AW] | lcount[STAT_AW];
    assign last_bytes = (mac_last_bytes_i == 2'd0) ? 3'd4 : {1'b0, mac_last_bytes_i};

    assign swd[31] = 1'b0;
    assign swd[ST_FILTER_BIT] = mac_stat_filter_fail_i;
    assign swd[29:ST_LEN_LSB] = mac_stat_len_i;
    assign swd[ST_ERROR_SUMMARY_BIT] = mac_stat_flags_i[ST_RUNT_BIT] | mac_stat_flags_i[ST_TOOLONG_BIT]
                          | mac_stat_flags_i[ST_LATECOL_BIT] | mac_stat_flags_i[ST_CRC_BIT];
    assign swd[14] = 1'b0;
    assign swd[ST_BCAST_BIT] = mac_stat_bcast_i;
    assign swd[12:0] = mac_stat_flags_i & ST_FLAG_MASK;

    always_comb begin
        nxt_wstate = wstate_ff;
        nxt_carry = carry_ff;
        nxt_shift = shift_ff;
        nxt_fill = fill_ff;
        nxt_wcnt = wcnt_ff;
        nxt_dwr = dwr_ptr_ff;
        nxt_swr = swr_ptr_ff;
        nxt_halted = halted_ff;
        dwe = 1'b0;
        dwd = carry_ff;
        swe = 1'b0;
        stat_ovr = 1'b0;
        mac_ready_o = 1'b0;
        mac_stat_ready_o = 1'b0;
        unique case (wstate_ff)
            W_IDLE: begin
                if (rx_enable_ff && mac_valid_i) begin
                    nxt_shift = offset_ff[1:0];
                    nxt_fill = offset_ff[4:2];
                    nxt_carry = 32'h0000_0000;
                    nxt_wcnt = 14'h0000;
                    nxt_wstate = W_FILL;
                end
            end
            W_FILL: begin
                if (fill_ff == 3'd0) begin
                    nxt_wstate = W_DATA;
                end else if (dspace) begin
                    dwe = 1'b1;
                    nxt_fill = fill_ff - 3'd1;
                end
            end
            W_DATA: begin
                mac_ready_o = dspace;
                if (mac_valid_i && dspace) begin
                    dwe = 1'b1;
                    dwd = merge_word(mac_data_i, carry_ff, shift_ff);
                    nxt_carry = spill_word(mac_data_i, shift_ff);
                    if (mac_last_i) begin
                        nxt_wstate = ((last_bytes + {1'b0, shift_ff}) > 3'd4) ? W_TAIL : W_PAD;
                    end
                end
            end
            W_TAIL: begin
                if (dspace) begin
                    dwe = 1'b1;
                    nxt_wstate = W_PAD;
                end
            end
            W_PAD: begin
                if (!pad_en_ff || wcnt_ff[PAD_LOG2-1:0] == '0) begin
                    nxt_wstate = W_STAT;
                end else if (dspace) begin
                    dwe = 1'b1;
                end
            end
            W_STAT: begin
                mac_stat_ready_o = 1'b1;
                if (mac_stat_valid_i) begin
                    // On overrun the frame's status and length are lost; its data stays queued
                    swe = ~sfull;
                    stat_ovr = sfull;
                    nxt_wstate = W_IDLE;
                end
            end
        endcase
        if (dwe) begin
            nxt_dwr = dwr_ptr_ff + 1'b1;
            nxt_wcnt = wcnt_ff + 14'd1;
        end
        if (swe) begin
            nxt_swr = swr_ptr_ff + 1'b1;
        end
        if (rx_enable_ff) begin
            nxt_halted = 1'b0;
        end else if (wstate_ff == W_IDLE) begin
            nxt_halted = 1'b1;
        end
        if (flush_ff) begin
            nxt_dwr = '0;
            nxt_swr = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wstate_ff <= W_IDLE;
            carry_ff <= 32'h0000_0000;
            shift_ff <= 2'd0;
            fill_ff <= 3'd0;
            wcnt_ff <= 14'h0000;
            dwr_ptr_ff <= '0;
            swr_ptr_ff <= '0;
            halted_ff <= 1'b0;
            halted_pulse_ff <= 1'b0;
        end else begin
            wstate_ff <= nxt_wstate;
            carry_ff <= nxt_carry;
            shift_ff <= nxt_shift;
            fill_ff <= nxt_fill;
            wcnt_ff <= nxt_wcnt;
            dwr_ptr_ff <= nxt_dwr;
            swr_ptr_ff <= nxt_swr;
            halted_ff <= nxt_halted;
            halted_pulse_ff <= nxt_halted & ~halted_ff;
        end
    end

    rxdp_mem #(.WIDTH(32), .AW(DATA_AW)) u_data_mem (
        .clk_i(clk_i), .we_i(dwe), .waddr_i(dwr_ptr_ff[DATA_AW-1:0]), .wdata_i(dwd),
        .raddr_i(drd_ptr_ff[DATA_AW-1:0]), .rdata_o(drdata));
    rxdp_mem #(.WIDTH(32), .AW(STAT_AW)) u_stat_mem (
        .clk_i(clk_i), .we_i(swe), .waddr_i(swr_ptr_ff[STAT_AW-1:0]), .wdata_i(swd),
        .raddr_i(srd_ptr_ff[STAT_AW-1:0]), .rdata_o(srdata));
    // Packet word counts, consumed by data reads and by the skip command
    rxdp_mem #(.WIDTH(14), .AW(STAT_AW)) u_len_mem (
        .clk_i(clk_i), .we_i(swe), .waddr_i(swr_ptr_ff[STAT_AW-1:0]), .wdata_i(wcnt_ff),
        .raddr_i(lrd_ptr_ff[STAT_AW-1:0]), .rdata_o(lhead));

    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;

    always_comb begin
        nxt_ack = acc;
        nxt_dat = dat_ff;
        nxt_drd = drd_ptr_ff;
        nxt_srd = srd_ptr_ff;
        nxt_lrd = lrd_ptr_ff;
        nxt_rd_in_pkt = rd_in_pkt_ff;
        nxt_dhalf = dhalf_ff;
        nxt_shalf = shalf_ff;
        nxt_rx_enable = rx_enable_ff;
        nxt_pad_en = pad_en_ff;
        nxt_offset = offset_ff;
        nxt_skip = skip_ff;
        nxt_flush = flush_ff;
        err_set = stat_ovr;
        err_clr = 1'b0;
        lpop = 1'b0;
        if (acc && !wb_we_i) begin
            nxt_dat = 16'h0000;
            unique case (wb_adr_i)
                ADDR_RX_DATA: begin
                    if (dcount == '0) begin
                        err_set = 1'b1;
                    end else begin
                        nxt_dat = dhalf_ff ? drdata[31:16] : drdata[15:0];
                        nxt_dhalf = ~dhalf_ff;
                        if (dhalf_ff) begin
                            nxt_drd = drd_ptr_ff + 1'b1;
                            nxt_rd_in_pkt = rd_in_pkt_ff + 14'd1;
                            if (lready_ff && rd_in_pkt_ff + 14'd1 == lhead) begin
                                lpop = 1'b1;
                                nxt_rd_in_pkt = 14'h0000;
                            end
                        end
                    end
                end
                ADDR_RX_STATUS: begin
                    if (scount == '0) begin
                        err_set = 1'b1;
                    end else begin
                        nxt_dat = shalf_ff ? srdata[31:16] : srdata[15:0];
                        nxt_shalf = ~shalf_ff;
                        if (shalf_ff) begin
                            nxt_srd = srd_ptr_ff + 1'b1;
                        end
                    end
                end
                ADDR_LEVEL_DATA: nxt_dat = 16'({dcount, 2'b00});
                ADDR_LEVEL_STAT: nxt_dat = 16'(scount);
                ADDR_CONTROL: nxt_dat = {3'b000, offset_ff, 4'h0, rx_enable_ff, pad_en_ff, flush_ff, skip_ff};
                ADDR_ERROR: nxt_dat = {13'h0000, wstate_ff != W_IDLE, halted_ff, err_ff};
                default: nxt_dat = 16'h0000;
            endcase
        end
        if (skip_ff && !flush_ff) begin
            if (lready_ff) begin
                nxt_drd = drd_ptr_ff + (DATA_AW + 1)'(lhead - rd_in_pkt_ff);
                nxt_rd_in_pkt = 14'h0000;
                nxt_dhalf = 1'b0;
                lpop = 1'b1;
                nxt_skip = 1'b0;
            end else if (lcount == '0) begin
                nxt_skip = 1'b0;
            end
        end
        if (lpop) begin
            nxt_lrd = lrd_ptr_ff + 1'b1;
        end
        if (flush_ff) begin
            nxt_drd = '0;
            nxt_srd = '0;
            nxt_lrd = '0;
            nxt_rd_in_pkt = 14'h0000;
            nxt_dhalf = 1'b0;
            nxt_shalf = 1'b0;
            nxt_skip = 1'b0;
            nxt_flush = 1'b0;
        end
        if (acc && wb_we_i) begin
            if (wb_adr_i == ADDR_CONTROL && wb_sel_i[0]) begin
                nxt_skip = nxt_skip | wb_dat_i[CTL_SKIP_BIT];
                nxt_flush = nxt_flush | wb_dat_i[CTL_FLUSH_BIT];
                nxt_pad_en = wb_dat_i[CTL_PAD_BIT];
                nxt_rx_enable = wb_dat_i[CTL_ENABLE_BIT];
            end
            if (wb_adr_i == ADDR_CONTROL && wb_sel_i[1]) begin
                nxt_offset = wb_dat_i[CTL_OFFSET_LSB+4:CTL_OFFSET_LSB];
            end
            if (wb_adr_i == ADDR_ERROR && wb_sel_i[0]) begin
                err_clr = wb_dat_i[ERR_FLAG_BIT];
            end
        end
        // A new error in the clearing cycle survives
        nxt_err = (err_ff & ~err_clr) | err_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 16'h0000;
            drd_ptr_ff <= '0;
            srd_ptr_ff <= '0;
            lrd_ptr_ff <= '0;
            rd_in_pkt_ff <= 14'h0000;
            dhalf_ff <= 1'b0;
            shalf_ff <= 1'b0;
            rx_enable_ff <= RST_RX_ENABLE;
            pad_en_ff <= RST_PAD_EN;
            offset_ff <= RST_OFFSET;
            skip_ff <= 1'b0;
            flush_ff <= 1'b0;
            err_ff <= 1'b0;
            lready_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            drd_ptr_ff <= nxt_drd;
            srd_ptr_ff <= nxt_srd;
            lrd_ptr_ff <= nxt_lrd;
            rd_in_pkt_ff <= nxt_rd_in_pkt;
            dhalf_ff <= nxt_dhalf;
            shalf_ff <= nxt_shalf;
            rx_enable_ff <= nxt_rx_enable;
            pad_en_ff <= nxt_pad_en;
            offset_ff <= nxt_offset;
            skip_ff <= nxt_skip;
            flush_ff <= nxt_flush;
            err_ff <= nxt_err;
            // Head length is trusted only once the registered read has caught up
            lready_ff <= (lcount != '0) & ~lpop & ~flush_ff;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign rx_error_flag_o = err_ff;
    assign receiver_halted_pulse_o = halted_pulse_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_data_push_ptr: assert property (dwe && !flush_ff |=> dwr_ptr_ff == $past(dwr_ptr_ff) + 1'b1)
        else $error("data write pointer did not advance");
    a_status_push: assert property (wstate_ff == W_STAT && mac_stat_valid_i && !sfull && !flush_ff
        |=> swr_ptr_ff == $past(swr_ptr_ff) + 1'b1 && wstate_ff == W_IDLE)
        else $error("status word not queued");
    a_level_stat: assert property (acc && !wb_we_i && wb_adr_i == ADDR_LEVEL_STAT
        |=> wb_ack_o && wb_dat_o == 16'($past(scount)))
        else $error("status level read wrong");
    a_underrun_err: assert property (acc && !wb_we_i && wb_adr_i == ADDR_RX_DATA && dcount == '0
        |=> rx_error_flag_o)
        else $error("underrun did not flag error");
    a_offset_fill: assert property (wstate_ff == W_IDLE && rx_enable_ff && mac_valid_i
        |=> wstate_ff == W_FILL && fill_ff == $past(offset_ff[4:2]) && shift_ff == $past(offset_ff[1:0]))
        else $error("offset not loaded at frame start");
    a_pad_multiple: assert property (wstate_ff == W_PAD ##1 wstate_ff == W_STAT
        |-> $past(!pad_en_ff) || wcnt_ff[PAD_LOG2-1:0] == '0)
        else $error("padded packet not burst aligned");
    a_skip_done: assert property (skip_ff && lready_ff && !flush_ff
        |=> !skip_ff && rd_in_pkt_ff == 14'h0000 && lrd_ptr_ff == $past(lrd_ptr_ff) + 1'b1)
        else $error("skip did not drop head packet");
    a_skip_keeps_stat: assert property (skip_ff && !flush_ff && !acc |=> srd_ptr_ff == $past(srd_ptr_ff))
        else $error("skip moved status FIFO");
    a_flush_reset: assert property (flush_ff
        |=> !flush_ff && drd_ptr_ff == '0 && srd_ptr_ff == '0 && swr_ptr_ff == '0 && lrd_ptr_ff == '0)
        else $error("flush did not reset pointers");
    a_status_layout: assert property (swe |-> !swd[31] && !swd[14] && swd[29:16] == mac_stat_len_i
        && swd[ST_ERROR_SUMMARY_BIT] == |(mac_stat_flags_i & 13'h08C2))
        else $error("status word layout wrong");
    a_halt_pulse: assert property ($fell(rx_enable_ff) && wstate_ff == W_IDLE ##1 wstate_ff == W_IDLE
        |-> receiver_halted_pulse_o)
        else $error("no halt pulse");

    c_skip: cover property (skip_ff && lready_ff);
    c_flush: cover property (flush_ff);
    c_pad_frame: cover property (wstate_ff == W_PAD && pad_en_ff && dwe);
endmodule

// ### bench/rxdp_mac_model.sv
`timescale 1ns/10ps
module rxdp_mac_model (
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic stat_ready_i,
    output logic [31:0] data_o,
    output logic valid_o,
    output logic last_o,
    output logic [1:0] last_bytes_o,
    output logic stat_valid_o,
    output logic [13:0] stat_len_o,
    output logic filter_fail_o,
    output logic bcast_o,
    output logic [12:0] flags_o
);
    // Waits that ran out; the bench checks once, at the end of the overrun test, that there were none
    int stalls = 0;

    initial begin
        {data_o, valid_o, last_o, last_bytes_o} = '0;
        {stat_valid_o, stat_len_o, filter_fail_o, bcast_o, flags_o} = '0;
    end

    // Whole words only; status goes out after the last word is taken
    task automatic send(input int nw, input logic [31:0] base, input logic ff, input logic bc,
                        input logic [12:0] fl);
        int n;
        @(posedge clk_i);
        for (int i = 0; i < nw; i++) begin
            valid_o <= 1'b1;
            data_o <= base + 32'(i);
            last_o <= (i == nw - 1);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (ready_i !== 1'b1 && n < 200);
            if (n >= 200) stalls++;
        end
        // Released lines show garbage, not the last word
        valid_o <= 1'b0;
        last_o <= 1'b0;
        data_o <= ~data_o;
        stat_valid_o <= 1'b1;
        stat_len_o <= 14'(nw * 4);
        filter_fail_o <= ff;
        bcast_o <= bc;
        flags_o <= fl;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (stat_ready_i !== 1'b1 && n < 200);
        if (n >= 200) stalls++;
        stat_valid_o <= 1'b0;
        stat_len_o <= ~stat_len_o;
        flags_o <= ~flags_o;
    endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import rxdp_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [1:0] wb_sel_i, lbytes;
    logic [15:0] wb_dat_i, wb_dat_o, rd;
    logic [31:0] mdata, w;
    logic mvalid, mlast, mready, svalid, sready, filt, bcast, err_flag, halted;
    logic [13:0] slen;
    logic [12:0] flags;
    int error_cnt = 0;
    int num_checks = 0;

    rxdp_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mac_data_i(mdata), .mac_valid_i(mvalid),
        .mac_last_i(mlast), .mac_last_bytes_i(lbytes), .mac_ready_o(mready),
        .mac_stat_valid_i(svalid), .mac_stat_len_i(slen), .mac_stat_filter_fail_i(filt),
        .mac_stat_bcast_i(bcast), .mac_stat_flags_i(flags), .mac_stat_ready_o(sready),
        .rx_error_flag_o(err_flag), .receiver_halted_pulse_o(halted));
    rxdp_mac_model mac (.clk_i(clk_i), .ready_i(mready), .stat_ready_i(sready), .data_o(mdata),
        .valid_o(mvalid), .last_o(mlast), .last_bytes_o(lbytes), .stat_valid_o(svalid),
        .stat_len_o(slen), .filter_fail_o(filt), .bcast_o(bcast), .flags_o(flags));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) chk({31'h0, wb_ack_o}, 32'h0000_0001);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd32(input logic [7:0] a);
        bus(1'b0, a, 16'h0000);
        w[15:0] = rd;
        bus(1'b0, a, 16'h0000);
        w[31:16] = rd;
    endtask

    function automatic logic [15:0] cv(input logic en, input logic pad, input logic [4:0] off);
        cv = 16'h0000;
        cv[CTL_ENABLE_BIT] = en;
        cv[CTL_PAD_BIT] = pad;
        cv[CTL_OFFSET_LSB +: 5] = off;
    endfunction

    function automatic logic [31:0] stw(input int len, input logic ff, input logic bc,
                                        input logic [12:0] fl);
        stw = 32'h0000_0000;
        stw[29:16] = 14'(len);
        stw[ST_FILTER_BIT] = ff;
        stw[ST_BCAST_BIT] = bc;
        stw[12:0] = fl & ST_FLAG_MASK;
        stw[ST_ERROR_SUMMARY_BIT] = fl[ST_RUNT_BIT] | fl[ST_TOOLONG_BIT] | fl[ST_LATECOL_BIT] | fl[ST_CRC_BIT];
    endfunction

    task automatic lvl(input logic [15:0] dexp, input logic [15:0] sexp);
        bus(1'b0, ADDR_LEVEL_DATA, 16'h0000);
        chk({16'h0000, rd}, {16'h0000, dexp});
        bus(1'b0, ADDR_LEVEL_STAT, 16'h0000);
        chk({16'h0000, rd}, {16'h0000, sexp});
    endtask

    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, ADDR_CONTROL, 16'h0000);
            n++;
        end while (rd[b] !== 1'b0 && n < 100);
        chk({31'h0, rd[b]}, 32'h0000_0000);
    endtask

    task automatic soft_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic t_basic;
        lvl(16'h0000, 16'h0000);
        bus(1'b1, ADDR_CONTROL, cv(1'b1, 1'b0, 5'h00));
        mac.send(2, 32'hA5A5_0000, 1'b1, 1'b1, 13'h0002);
        lvl(16'h0008, 16'h0001);
        rd32(ADDR_RX_STATUS);
        chk(w, stw(8, 1'b1, 1'b1, 13'h0002));
        rd32(ADDR_RX_DATA);
        chk(w, 32'hA5A5_0000);
        rd32(ADDR_RX_DATA);
        chk(w, 32'hA5A5_0001);
    endtask

    task automatic t_underrun;
        bus(1'b0, ADDR_RX_DATA, 16'h0000);
        chk({16'h0000, rd}, 32'h0000_0000);
        chk({31'h0, err_flag}, 32'h0000_0001);
        bus(1'b1, ADDR_ERROR, 16'h0001);
        chk({31'h0, err_flag}, 32'h0000_0000);
        soft_reset();
    endtask

    // Offset 6: one filler word and a two-byte shift, so a tail word spills; two pad words make eight
    task automatic t_offset;
        logic [31:0] base [2];
        base[0] = 32'hB000_0000;
        base[1] = 32'hC000_0000;
        bus(1'b1, ADDR_CONTROL, cv(1'b1, 1'b1, 5'h06));
        mac.send(4, base[0], 1'b1, 1'b0, 13'h0840);
        mac.send(4, base[1], 1'b0, 1'b0, 13'h0301);
        lvl(16'h0040, 16'h0002);
        rd32(ADDR_RX_STATUS);
        chk(w, stw(16, 1'b1, 1'b0, 13'h0840));
        rd32(ADDR_RX_STATUS);
        chk(w, stw(16, 1'b0, 1'b0, 13'h0301));
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                rd32(ADDR_RX_DATA);
                if (i >= 1 && i <= 4) chk({16'h0000, w[31:16]}, 32'(i - 1));
                if (i >= 2 && i <= 5) chk({16'h0000, w[15:0]}, {16'h0000, base[p][31:16]});
            end
        end
        lvl(16'h0000, 16'h0000);
    endtask

    task automatic t_skip;
        bus(1'b1, ADDR_CONTROL, cv(1'b1, 1'b0, 5'h00));
        mac.send(5, 32'hD000_0000, 1'b0, 1'b0, 13'h0000);
        mac.send(2, 32'hE000_0000, 1'b0, 1'b0, 13'h0080);
        bus(1'b1, ADDR_CONTROL, cv(1'b1, 1'b0, 5'h00) | 16'h0001);
        poll(CTL_SKIP_BIT);
        lvl(16'h0008, 16'h0002);
        rd32(ADDR_RX_DATA);
        chk(w, 32'hE000_0000);
    endtask

    task automatic t_flush;
        int n;
        bus(1'b1, ADDR_CONTROL, cv(1'b0, 1'b0, 5'h00));
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (halted !== 1'b1 && n < 40);
        chk({31'h0, halted}, 32'h0000_0001);
        bus(1'b0, ADDR_ERROR, 16'h0000);
        chk({16'h0000, rd}, 32'h0000_0002);
        bus(1'b1, ADDR_CONTROL, 16'h0002);
        poll(CTL_FLUSH_BIT);
        lvl(16'h0000, 16'h0000);
    endtask

    task automatic t_overrun;
        bus(1'b1, ADDR_CONTROL, cv(1'b1, 1'b0, 5'h00));
        for (int i = 0; i < 17; i++) mac.send(1, 32'hF000_0000 + 32'(i), 1'b0, 1'b0, 13'h0000);
        @(posedge clk_i);
        chk({31'h0, err_flag}, 32'h0000_0001);
        lvl(16'h0044, 16'h0010);
        chk(32'(mac.stalls), 32'h0000_0000);
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 2'b11;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_basic();
        t_underrun();
        t_offset();
        t_skip();
        t_flush();
        t_overrun();
        complete_run();
    end

    // Whole sequence needs a few hundred cycles
    initial begin
        #(40 * 30000);
        error_cnt++;
        complete_run();
    end
endmodule
